// *** pkg/ostlp_pkg.sv ***
// Purpose: shared constants for the one-shot low-power timer
// Assumes: 100 MHz system clock, 32 kHz peripheral clock sampled as a pin
// Notes:   field encodings and count values used by the timer and bench; the filter uses only NOISE_FILTER_LEN

package ostlp_pkg;

  // ----------------------------------------------------------------
  // mode and field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0]  MODE_ONE_SHOT      = 4'h0;
  localparam logic [3:0]  MODE_TRIG_ONE_SHOT = 4'hB;
  localparam logic [1:0]  IRQCFG_RELOAD_ONLY = 2'h3;
  localparam logic [2:0]  PRESCALE_DIV1      = 3'h0;
  localparam logic        CLKSRC_SYSTEM      = 1'h0;
  localparam logic        CLKSRC_PERIPH      = 1'h1;
  localparam logic        INSRC_GPIO         = 1'h0;

  // ----------------------------------------------------------------
  // count values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESTART      = 16'h0001;
  localparam logic [15:0] COUNT_WRAP         = 16'h0000;
  localparam logic [15:0] COUNT_RESET        = 16'h0001;
  localparam logic [15:0] RELOAD_RESET       = 16'hFFFF;
  localparam logic [6:0]  PRESCALE_RESET     = 7'h00;
  localparam int          NOISE_FILTER_LEN   = 4;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OSTLP_IDLE  = 2'b00,
    OSTLP_COUNT = 2'b01,
    OSTLP_PULSE = 2'b11
  } ostlp_state_t;

endpackage

// *** design/ostlp_filter.sv ***
// Purpose: glitch filter on the timer input; when enabled, output changes only when all samples agree, else input passes straight through
// Assumes: input already synchronised to clk_sys_i
// Notes:   advances only on tick_i so it keeps running on the slow clock

`timescale 1ns/1ps

module ostlp_filter #(
  parameter int LEN = ostlp_pkg::NOISE_FILTER_LEN
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic enable_i,
  input  wire logic din_i,
  output logic      dout_o
);

  logic [LEN-1:0] hist_reg;
  logic           out_reg;
  wire            all_high = &hist_reg;
  wire            all_low  = ~|hist_reg;

  // ----------------------------------------------------------------
  // history shift and decision
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hist_reg <= '0;
      out_reg  <= 1'b0;
    end else if (tick_i) begin
      hist_reg <= {hist_reg[LEN-2:0], din_i};
      if (all_high) begin
        out_reg <= 1'b1;
      end else if (all_low) begin
        out_reg <= 1'b0;
      end
    end
  end

  assign dout_o = enable_i ? out_reg : din_i;

endmodule

// *** design/ostlp_timer.sv ***
// Purpose: 16-bit reloadable up-counter, one-shot and triggered one-shot
// Assumes: periph clock and timer input are pins, synchronised here
// Notes:   control bits are plain ports; start value loads while disabled
//
// Functional notes
// [R1] stop mode: peripheral clock keeps timer counting
// [R2] stop mode interrupt triggers recovery and request
// [R3] wake sets stop flag and request bit
// [R4] noise filter keeps running during stop; here only on the peripheral clock, frozen on the system clock
// [R5] system clock: freeze in stop, resume after
// [R6] enable cleared gates timer, registers still writable
// [R7] one-shot: reload hit, irq, 0001H, disable
// [R8] one-shot output inverts for one clock
// [R9] software flips polarity for permanent change
// [R10] software follows documented setup order
// [R11] counter advances on prescaled timer clocks
// [R12] triggered: idle until polarity-selected input edge
// [R13] after trigger count up to reload
// [R14] triggered reload: pulse, irq, count 0001H
// [R15] after time-out stay enabled, await trigger
// [R16] mode 1011B means triggered one-shot
// [R17] irq config 11B: reload interrupts only
// [R18] prescale 000B divides by one
// [R19] clock source 1 selects 32kHz clock
// [R20] polarity 0: rising trigger, idle low
// [R21] input source 0 selects gpio pin
// [R22] count wraps FFFFH to 0000H
// [R23] clock source field picks system or peripheral
// [R24] software disables before changing control
// [R25] count steps only on prescaler ticks

`timescale 1ns/1ps

module ostlp_timer #(
  parameter int CW = 16,
  parameter int PW = 7
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic          periph_clk_i,
  input  wire logic          gpio_in_i,
  input  wire logic          alt_in_i,
  input  wire logic          stop_mode_i,
  input  wire logic          enable_set_i,
  input  wire logic          enable_clr_i,
  input  wire logic [3:0]    mode_select_field_i,
  input  wire logic [2:0]    prescale_select_field_i,
  input  wire logic [1:0]    irq_config_field_i,
  input  wire logic          edge_and_output_polarity_i,
  input  wire logic          clock_source_select_i,
  input  wire logic          input_source_select_i,
  input  wire logic          filter_enable_i,
  input  wire logic          out_enable_i,
  input  wire logic          irq_enable_i,
  input  wire logic          count_wr_i,
  input  wire logic [CW-1:0] count_wdata_i,
  input  wire logic          reload_wr_i,
  input  wire logic [CW-1:0] reload_wdata_i,
  input  wire logic          stop_flag_clr_i,
  input  wire logic          irq_req_clr_i,
  output logic               count_enable_bit_o,
  output logic [CW-1:0]      count_o,
  output logic [CW-1:0]      reload_o,
  output logic               timer_out_o,
  output logic               timer_out_oe_o,
  output logic               irq_pulse_o,
  output logic               irq_req_o,
  output logic               stop_flag_o,
  output logic               stop_recovery_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pclk_sync_reg;
  logic [1:0] gpio_sync_reg;
  logic [1:0] alt_sync_reg;
  logic       pclk_last_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pclk_sync_reg <= 2'h0;
      gpio_sync_reg <= 2'h0;
      alt_sync_reg  <= 2'h0;
      pclk_last_reg <= 1'b0;
    end else begin
      pclk_sync_reg <= {pclk_sync_reg[0], periph_clk_i};
      gpio_sync_reg <= {gpio_sync_reg[0], gpio_in_i};
      alt_sync_reg  <= {alt_sync_reg[0], alt_in_i};
      pclk_last_reg <= pclk_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // timer clock enable selection
  // ----------------------------------------------------------------
  wire pclk_rise   = pclk_sync_reg[1] & ~pclk_last_reg;
  wire use_periph  = (clock_source_select_i == ostlp_pkg::CLKSRC_PERIPH); // [R19] [R23]
  // system clock freezes in stop; periph clock keeps running
  wire sys_tick    = ~stop_mode_i;                                        // [R5]
  wire tmr_tick    = use_periph ? pclk_rise : sys_tick;                   // [R1] [R23]

  // ----------------------------------------------------------------
  // input selection and noise filter
  // ----------------------------------------------------------------
  wire raw_in = (input_source_select_i == ostlp_pkg::INSRC_GPIO) ?
                gpio_sync_reg[1] : alt_sync_reg[1];                       // [R21]
  logic filt_in;
  logic filt_last_reg;

  // filter runs on the timer clock, so with the system clock source it stops in stop mode
  ostlp_filter #(
    .LEN (ostlp_pkg::NOISE_FILTER_LEN)
  ) u_filter (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (tmr_tick),
    .enable_i  (filter_enable_i),
    .din_i     (raw_in),
    .dout_o    (filt_in)
  );                                                                      // [R4]

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [PW:0] prescale_div(input logic [2:0] sel);
    prescale_div = (PW+1)'(1) << sel;                                     // [R18]
  endfunction

  logic           en_reg;
  logic [CW-1:0]  count_reg;
  logic [CW-1:0]  reload_reg;
  logic [PW-1:0]  pre_reg;
  ostlp_pkg::ostlp_state_t state_reg;
  ostlp_pkg::ostlp_state_t state_next;
  logic           out_reg;
  logic           irq_pulse_reg;
  logic           irq_req_reg;
  logic           stop_flag_reg;

  wire is_trig    = (mode_select_field_i == ostlp_pkg::MODE_TRIG_ONE_SHOT); // [R16]
  wire [PW:0] div = prescale_div(prescale_select_field_i);
  wire pre_last   = ({1'b0, pre_reg} == (div - (PW+1)'(1)));
  // prescaler, count and trigger gated by enable; register writes still reach state
  wire run_tick   = en_reg & tmr_tick;                                    // [R6]
  wire cnt_tick   = run_tick & pre_last;                                  // [R11] [R25]
  wire hit        = (count_reg == reload_reg);
  wire rise_in    = filt_in & ~filt_last_reg;
  wire fall_in    = ~filt_in & filt_last_reg;
  // polarity 0 selects rising edge trigger
  wire trig_edge  = edge_and_output_polarity_i ? fall_in : rise_in;       // [R12] [R20]
  wire counting   = (state_reg == ostlp_pkg::OSTLP_COUNT);
  // reload seen on the timer clock after the count reaches it
  wire reload_evt = counting & run_tick & hit;                            // [R7] [R11]
  wire irq_ok     = (irq_config_field_i == ostlp_pkg::IRQCFG_RELOAD_ONLY) |
                    (irq_config_field_i[1] == 1'b0);                      // [R17]

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ostlp_pkg::OSTLP_IDLE: begin
        if (en_reg && (!is_trig || (run_tick && trig_edge))) begin
          state_next = ostlp_pkg::OSTLP_COUNT;                            // [R12] [R13]
        end
      end
      ostlp_pkg::OSTLP_COUNT: begin
        if (!en_reg) begin
          state_next = ostlp_pkg::OSTLP_IDLE;
        end else if (reload_evt) begin
          state_next = ostlp_pkg::OSTLP_PULSE;
        end
      end
      ostlp_pkg::OSTLP_PULSE: begin
        // pulse lasts one timer clock then back to idle
        if (tmr_tick) begin
          state_next = ostlp_pkg::OSTLP_IDLE;                             // [R15]
        end
      end
      default: state_next = ostlp_pkg::OSTLP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg     <= ostlp_pkg::OSTLP_IDLE;
      filt_last_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      if (tmr_tick) begin
        filt_last_reg <= filt_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
    end else if (reload_evt && !is_trig) begin
      en_reg <= 1'b0;                                                     // [R7]
    end else if (enable_clr_i) begin
      en_reg <= 1'b0;
    end else if (enable_set_i) begin
      en_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg <= ostlp_pkg::PRESCALE_RESET;
    end else if (!counting) begin
      pre_reg <= ostlp_pkg::PRESCALE_RESET;
    end else if (run_tick) begin
      pre_reg <= pre_last ? ostlp_pkg::PRESCALE_RESET : pre_reg + PW'(1); // [R11]
    end
  end

  // ----------------------------------------------------------------
  // count and reload registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg  <= ostlp_pkg::COUNT_RESET;
      reload_reg <= ostlp_pkg::RELOAD_RESET;
    end else begin
      if (reload_wr_i) begin
        reload_reg <= reload_wdata_i;
      end
      if (count_wr_i && !en_reg) begin
        count_reg <= count_wdata_i;                                       // [R25]
      end else if (reload_evt) begin
        count_reg <= ostlp_pkg::COUNT_RESTART;                            // [R7] [R14]
      end else if (counting && cnt_tick) begin
        // full-scale roll passes through zero
        count_reg <= (count_reg == {CW{1'b1}}) ?
                     ostlp_pkg::COUNT_WRAP : count_reg + CW'(1);          // [R22]
      end
    end
  end

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  // registered from the next state so the pin flips with the irq pulse
  wire pulse_on = (state_next == ostlp_pkg::OSTLP_PULSE);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      out_reg <= 1'b0;
    end else begin
      // idle level follows polarity; inverted for one timer clock
      out_reg <= edge_and_output_polarity_i ^ pulse_on;                   // [R8] [R14] [R20]
    end
  end

  // ----------------------------------------------------------------
  // interrupt, stop recovery and status
  // ----------------------------------------------------------------
  wire irq_evt  = reload_evt & irq_ok;
  wire wake_evt = irq_evt & irq_enable_i & stop_mode_i;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_pulse_reg <= 1'b0;
      irq_req_reg   <= 1'b0;
      stop_flag_reg <= 1'b0;
    end else begin
      irq_pulse_reg <= irq_evt;                                           // [R7] [R14]
      // set wins over clear
      if (irq_evt) begin
        irq_req_reg <= 1'b1;                                              // [R2] [R3]
      end else if (irq_req_clr_i) begin
        irq_req_reg <= 1'b0;
      end
      if (wake_evt) begin
        stop_flag_reg <= 1'b1;                                            // [R3]
      end else if (stop_flag_clr_i) begin
        stop_flag_reg <= 1'b0;
      end
    end
  end

  assign stop_recovery_o    = stop_mode_i & irq_enable_i & irq_req_reg;   // [R2]
  assign count_enable_bit_o = en_reg;
  assign count_o            = count_reg;
  assign reload_o           = reload_reg;
  assign timer_out_o        = out_reg;
  assign timer_out_oe_o     = out_enable_i;
  assign irq_pulse_o        = irq_pulse_reg;
  assign irq_req_o          = irq_req_reg;
  assign stop_flag_o        = stop_flag_reg;

endmodule

// *** verification/ostlp_timer_chk.sv ***
// Purpose: port checks on the one-shot timer
// Assumes: one clock, async high reset
// Notes:   bound onto ostlp_timer
`timescale 1ns/1ps
module ostlp_timer_chk #(
  parameter int CW = 16
) (
  input wire logic          clk_sys_i,
  input wire logic          rst_i,
  input wire logic          stop_mode_i,
  input wire logic          enable_set_i,
  input wire logic          enable_clr_i,
  input wire logic [3:0]    mode_select_field_i,
  input wire logic [2:0]    prescale_select_field_i,
  input wire logic          edge_and_output_polarity_i,
  input wire logic          clock_source_select_i,
  input wire logic          irq_enable_i,
  input wire logic          count_wr_i,
  input wire logic          count_enable_bit_o,
  input wire logic [CW-1:0] count_o,
  input wire logic          timer_out_o,
  input wire logic          irq_pulse_o,
  input wire logic          irq_req_o,
  input wire logic          stop_recovery_o
);
  // ----------------------------------------------
  // assertions
  // ----------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  wire logic trig_mode = (mode_select_field_i == ostlp_pkg::MODE_TRIG_ONE_SHOT);
  wire logic pol       = edge_and_output_polarity_i;

  a_pulse_single: assert property (irq_pulse_o |=> !irq_pulse_o)
    else $error("irq pulse too long");
  a_req_follows: assert property (irq_pulse_o |-> irq_req_o)
    else $error("request not set");
  a_wake_level: assert property (stop_recovery_o == (stop_mode_i && irq_enable_i && irq_req_o))
    else $error("recovery level wrong");
  a_sys_freeze: assert property ((stop_mode_i && !clock_source_select_i && !count_wr_i)[*2]
    |=> $stable(count_o))
    else $error("count moved in stop");
  a_off_hold: assert property ((!count_enable_bit_o && !count_wr_i)[*2] |=> $stable(count_o))
    else $error("count moved while off");
  a_oneshot_end: assert property (irq_pulse_o && !trig_mode && !$past(enable_set_i)
    && !$past(count_wr_i) |-> !count_enable_bit_o && count_o == ostlp_pkg::COUNT_RESTART)
    else $error("one-shot end wrong");
  a_trig_rearm: assert property (irq_pulse_o && trig_mode && !$past(enable_clr_i)
    |-> count_enable_bit_o && count_o == ostlp_pkg::COUNT_RESTART)
    else $error("triggered end wrong");
  a_out_pulse: assert property (irq_pulse_o && !clock_source_select_i
    && prescale_select_field_i == 3'h0 && $stable(pol)
    |-> timer_out_o != pol ##1 timer_out_o == pol)
    else $error("output pulse wrong");

  c_oneshot: cover property (irq_pulse_o && !trig_mode);
  c_trig: cover property (irq_pulse_o && trig_mode);
  c_wake: cover property (stop_recovery_o);
endmodule

bind ostlp_timer ostlp_timer_chk #(.CW(CW)) i_chk (
  .clk_sys_i, .rst_i, .stop_mode_i, .enable_set_i, .enable_clr_i, .mode_select_field_i,
  .prescale_select_field_i, .edge_and_output_polarity_i, .clock_source_select_i,
  .irq_enable_i, .count_wr_i, .count_enable_bit_o, .count_o, .timer_out_o, .irq_pulse_o,
  .irq_req_o, .stop_recovery_o
);

// *** verification/ostlp_pins.sv ***
// Purpose: pins around the timer: input pin and 32 kHz clock
// Assumes: bench drives level and glitch off the clock edge
// Notes:   unselected alternate pin never holds still
`timescale 1ns/1ps
module ostlp_pins #(
  parameter real HALF_NS = 15625.0
) (
  input  wire logic clk_sys_i,
  input  wire logic run_i,
  input  wire logic level_i,
  input  wire logic glitch_i,
  output logic      periph_clk_o,
  output logic      gpio_o,
  output logic      alt_o
);
  // ----------------------------------------------
  // drivers
  // ----------------------------------------------
  initial begin
    periph_clk_o = 1'h0;
    forever begin
      #(HALF_NS);
      periph_clk_o = run_i ? ~periph_clk_o : 1'h0;
    end
  end
  initial alt_o = 1'h0;
  always @(posedge clk_sys_i) alt_o <= ~alt_o;
  assign gpio_o = level_i ^ glitch_i;
endmodule

// *** verification/ostlp_timer_tb_top.sv ***
// Purpose: self-checking bench for the one-shot timer
// Assumes: 100 MHz clock, inputs driven at falling edge
// Notes:   one task per scenario
`timescale 1ns/1ps
module ostlp_timer_tb_top;
  logic        clk_sys_i, rst_i, periph_clk_i, gpio_in_i, alt_in_i, stop_mode_i;
  logic        enable_set_i, enable_clr_i, edge_and_output_polarity_i, clock_source_select_i;
  logic        input_source_select_i, filter_enable_i, out_enable_i, irq_enable_i;
  logic        count_wr_i, reload_wr_i, stop_flag_clr_i, irq_req_clr_i, run, level, glitch;
  logic [3:0]  mode_select_field_i;
  logic [2:0]  prescale_select_field_i;
  logic [1:0]  irq_config_field_i;
  logic [15:0] count_wdata_i, reload_wdata_i, count_o, reload_o;
  logic        count_enable_bit_o, timer_out_o, timer_out_oe_o, irq_pulse_o, irq_req_o;
  logic        stop_flag_o, stop_recovery_o;
  int          n_errors, comparisons;

  ostlp_timer i_dut (
    .clk_sys_i, .rst_i, .periph_clk_i, .gpio_in_i, .alt_in_i, .stop_mode_i, .enable_set_i,
    .enable_clr_i, .mode_select_field_i, .prescale_select_field_i, .irq_config_field_i,
    .edge_and_output_polarity_i, .clock_source_select_i, .input_source_select_i,
    .filter_enable_i, .out_enable_i, .irq_enable_i, .count_wr_i, .count_wdata_i,
    .reload_wr_i, .reload_wdata_i, .stop_flag_clr_i, .irq_req_clr_i, .count_enable_bit_o,
    .count_o, .reload_o, .timer_out_o, .timer_out_oe_o, .irq_pulse_o, .irq_req_o,
    .stop_flag_o, .stop_recovery_o
  );
  ostlp_pins i_pins (.clk_sys_i, .run_i(run), .level_i(level), .glitch_i(glitch),
    .periph_clk_o(periph_clk_i), .gpio_o(gpio_in_i), .alt_o(alt_in_i));

  // ----------------------------------------------
  // helpers
  // ----------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq_pulse_o !== 1'h1) begin
      tick(1);
      n++;
      if (n > lim) begin
        n_errors++;
        $display("BAD irq wait expected 1 seen 0");
        print_verdict();
      end
    end
  endtask
  task automatic setup(input logic [3:0] m, input logic [2:0] p, input logic src,
                       input logic [15:0] st, input logic [15:0] rl);
    enable_clr_i = 1'h1;
    mode_select_field_i = m;
    prescale_select_field_i = p;
    tick(1);
    enable_clr_i = 1'h0;
    clock_source_select_i = src;
    count_wr_i = 1'h1;
    count_wdata_i = st;
    reload_wr_i = 1'h1;
    reload_wdata_i = rl;
    irq_req_clr_i = 1'h1;
    stop_flag_clr_i = 1'h1;
    tick(1);
    count_wr_i = 1'h0;
    reload_wr_i = 1'h0;
    irq_req_clr_i = 1'h0;
    stop_flag_clr_i = 1'h0;
    tick(1);
    chk("start count", count_o, st);
  endtask
  task automatic start;
    enable_set_i = 1'h1;
    tick(1);
    enable_set_i = 1'h0;
  endtask

  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task automatic t_oneshot;
    int n1, n2;
    setup(ostlp_pkg::MODE_ONE_SHOT, ostlp_pkg::PRESCALE_DIV1, 1'h0, 16'h0001, 16'h0005);
    start();
    wait_irq(100, n1);
    chk("pulse out", timer_out_o, 1'h1);
    chk("count", count_o, 16'h0001);
    chk("enable", count_enable_bit_o, 1'h0);
    tick(1);
    chk("out back", timer_out_o, 1'h0);
    setup(ostlp_pkg::MODE_ONE_SHOT, 3'h2, 1'h0, 16'h0001, 16'h0005);
    start();
    wait_irq(100, n2);
    chk("div4 extra", 16'(n2 - n1), 16'h000C);
    $display("one-shot test done");
  endtask
  task automatic t_hold;
    logic [15:0] c;
    setup(ostlp_pkg::MODE_ONE_SHOT, 3'h4, ostlp_pkg::CLKSRC_SYSTEM, 16'h0001, 16'h0100);
    start();
    tick(100);
    stop_mode_i = 1'h1;
    tick(2);
    c = count_o;
    tick(200);
    chk("frozen", count_o, c);
    stop_mode_i = 1'h0;
    tick(100);
    chk("resumed", count_o > c, 1'h1);
    enable_clr_i = 1'h1;
    tick(1);
    enable_clr_i = 1'h0;
    tick(2);
    c = count_o;
    tick(200);
    chk("gated", count_o, c);
    $display("hold test done");
  endtask
  task automatic t_trig;
    int n;
    filter_enable_i = 1'h1;
    setup(ostlp_pkg::MODE_TRIG_ONE_SHOT, 3'h0, 1'h0, 16'h0001, 16'h0040);
    start();
    tick(20);
    chk("idle count", count_o, 16'h0001);
    chk("idle out", timer_out_o, 1'h0);
    glitch = 1'h1;
    tick(1);
    glitch = 1'h0;
    tick(20);
    chk("glitch", count_o, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      level = 1'h1;
      wait_irq(200, n);
      chk("pulse", timer_out_o, 1'h1);
      chk("count", count_o, 16'h0001);
      chk("enable", count_enable_bit_o, 1'h1);
      level = 1'h0;
      tick(30);
      chk("fall", count_o, 16'h0001);
    end
    chk("irq", irq_req_o, 1'h1);
    $display("triggered test done");
  endtask
  task automatic t_wrap;
    logic seen;
    seen = 1'h0;
    setup(ostlp_pkg::MODE_ONE_SHOT, 3'h0, 1'h0, 16'hFFFE, 16'h0002);
    start();
    for (int i = 0; i < 50 && irq_pulse_o !== 1'h1; i++) begin
      if (count_o === 16'h0000) seen = 1'h1;
      tick(1);
    end
    chk("wrap", seen, 1'h1);
    chk("irq", irq_pulse_o, 1'h1);
    $display("wrap test done");
  endtask
  task automatic t_wake;
    int n;
    run = 1'h1;
    irq_enable_i = 1'h1;
    setup(ostlp_pkg::MODE_ONE_SHOT, 3'h0, ostlp_pkg::CLKSRC_PERIPH, 16'h0001, 16'h0003);
    start();
    stop_mode_i = 1'h1;
    wait_irq(20000, n);
    tick(1);
    chk("slow clock", n > 2000, 1'h1);
    chk("stop flag", stop_flag_o, 1'h1);
    chk("irq req", irq_req_o, 1'h1);
    chk("recovery", stop_recovery_o, 1'h1);
    stop_mode_i = 1'h0;
    run = 1'h0;
    $display("wake test done");
  endtask

  initial begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {rst_i, stop_mode_i, enable_set_i, enable_clr_i, edge_and_output_polarity_i} = 5'h10;
    {clock_source_select_i, input_source_select_i, filter_enable_i, irq_enable_i} = 4'h0;
    {count_wr_i, reload_wr_i, stop_flag_clr_i, irq_req_clr_i, run, level, glitch} = 7'h00;
    out_enable_i = 1'h1;
    mode_select_field_i = 4'h0;
    prescale_select_field_i = 3'h0;
    irq_config_field_i = ostlp_pkg::IRQCFG_RELOAD_ONLY;
    count_wdata_i = 16'h0000;
    reload_wdata_i = 16'h0000;
    tick(8);
    rst_i = 1'h0;
    tick(1);
    chk("reset count", count_o, ostlp_pkg::COUNT_RESET);
    chk("reset reload", reload_o, ostlp_pkg::RELOAD_RESET);
    t_oneshot();
    t_hold();
    t_trig();
    t_wrap();
    t_wake();
    print_verdict();
  end
endmodule
